//--- common/pocbd_pkg.sv
// Summary of operation
// - Low option: hold reset until above clear
// - Dual option: hold reset until above high
// - Low option: reset follows clear comparator
// - Dual option: assert below low, release high
// - Dual option: fast rise adds stabilisation wait
// - Control bit 2 selects supply or pin
// - Control bit 1 selects interrupt or reset
// - Reset action: reset while input below
// - Interrupt action: interrupt on both edges
// - Control bit 0 reads below-threshold state
// - Detector reset sets cause bit 0
// - Two supply levels; pin threshold fixed
// - Detector keeps running in stop mode
// - Enable bit starts comparator, 10 us settle; code masks the reset action for one cycle only
// - Non-detector reset clears enable, action, source
// - Power-on clear zeroes reset-cause register
package pocbd_pkg;
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_LEVEL = 4'h4;
   localparam logic [3:0] ADR_CAUSE = 4'h8;
   localparam logic [3:0] ADR_IRQ_STAT = 4'hC;
   localparam logic [5:0] ADR_IRQ_MASK = 6'h10;
   localparam int CTRL_FLAG = 0;
   localparam int CTRL_ACTION = 1;
   localparam int CTRL_SOURCE = 2;
   localparam int CTRL_ENABLE = 7;
   localparam int CAUSE_BROWN = 0;
   localparam int CAUSE_WDOG = 4;
   localparam int IRQ_FALL = 0;
   localparam int IRQ_RISE = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam int CLK_MHZ = 125;
   localparam int FAST_RISE_US = 1930;
   localparam int STAB_WAIT_US = 5390;
   localparam int FAST_RISE_CYC = FAST_RISE_US * CLK_MHZ;
   localparam int STAB_WAIT_CYC = STAB_WAIT_US * CLK_MHZ;
endpackage : pocbd_pkg

//--- rtl/pocbd_top.sv
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module pocbd_top
   import pocbd_pkg::*;
#(
   parameter int FAST_RISE = FAST_RISE_CYC,
   parameter int STAB_WAIT = STAB_WAIT_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic threshold_option_bit,
   input wire logic above_clear_async,
   input wire logic above_high_async,
   input wire logic supply_above_async,
   input wire logic pin_above_async,
   input wire logic watchdog_reset,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic internal_reset,
   output logic detector_interrupt,
   output logic irq,
   output logic supply_level_select
);
   typedef enum logic [1:0] {PS_OFF, PS_RISING, PS_WAIT, PS_RUN} pocbd_por_e;
   localparam logic [5:0] ADR_MASK_FULL = ADR_IRQ_MASK;

   pocbd_por_e por_state;
   logic [3:0] sync_a, sync_b, sync_c;
   logic above_clear, above_high, supply_above, pin_above;
   logic detector_enable_bit, detect_action_select, detect_source_select;
   logic brownout_cause_flag, watchdog_cause_flag;
   logic [1:0] irq_stat, irq_mask;
   logic [31:0] fast_cnt, wait_cnt;
   logic below_sel, below_prev, flag_valid;
   logic por_reset, brown_reset;
   logic wr, rd_cause;

   // Unanimous vote of second and third stage
   function automatic logic agree(input logic b, input logic c, input logic prev);
      agree = (b == c) ? b : prev;
   endfunction : agree

   always_ff @(posedge clk_sys) begin
      sync_a <= {above_clear_async, above_high_async, supply_above_async, pin_above_async};
      sync_b <= sync_a;
      sync_c <= sync_b;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         {above_clear, above_high, supply_above, pin_above} <= 4'h0;
      end else begin
         above_clear <= agree(sync_b[3], sync_c[3], above_clear);
         above_high <= agree(sync_b[2], sync_c[2], above_high);
         supply_above <= agree(sync_b[1], sync_c[1], supply_above);
         pin_above <= agree(sync_b[0], sync_c[0], pin_above);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         por_state <= PS_OFF;
         fast_cnt <= 32'h0;
         wait_cnt <= 32'h0;
      end else if (!above_clear) begin
         por_state <= PS_OFF;
      end else begin
         case (por_state)
            PS_OFF: begin
               fast_cnt <= 32'h0;
               wait_cnt <= 32'h0;
               por_state <= threshold_option_bit ? PS_RISING : PS_RUN;
            end
            PS_RISING: begin
               if (above_high) begin
                  por_state <= (fast_cnt < 32'(FAST_RISE)) ? PS_WAIT : PS_RUN;
               end else begin
                  fast_cnt <= fast_cnt + 32'h1;
               end
            end
            PS_WAIT: begin
               if (wait_cnt >= 32'(STAB_WAIT) - 32'h1) begin
                  por_state <= PS_RUN;
               end else begin
                  wait_cnt <= wait_cnt + 32'h1;
               end
            end
            PS_RUN: por_state <= PS_RUN;
            default: por_state <= PS_OFF;
         endcase
      end
   end

   assign por_reset = (por_state != PS_RUN);
   // source select; pin threshold is fixed
   assign below_sel = detector_enable_bit & ~(detect_source_select ? pin_above : supply_above);
   assign brown_reset = below_sel & detect_action_select & flag_valid;

   // reset action ignores comparator for one cycle after enable; interrupt path is not masked
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flag_valid <= 1'b0;
      end else begin
         flag_valid <= detector_enable_bit;
      end
   end

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   // Full decode so an alias of the cause offset cannot clear it
   assign rd_cause = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & (wb_adr_i == {2'b00, ADR_CAUSE});

   always_ff @(posedge clk_sys) begin
      if (srst || por_reset || watchdog_reset) begin
         detector_enable_bit <= CTRL_RESET[CTRL_ENABLE];
         detect_action_select <= CTRL_RESET[CTRL_ACTION];
         detect_source_select <= CTRL_RESET[CTRL_SOURCE];
         supply_level_select <= 1'b0;
      end else if (wr && wb_adr_i == {2'b00, ADR_CTRL}) begin
         detector_enable_bit <= wb_dat_i[CTRL_ENABLE];
         detect_action_select <= wb_dat_i[CTRL_ACTION];
         detect_source_select <= wb_dat_i[CTRL_SOURCE];
      end else if (wr && wb_adr_i == {2'b00, ADR_LEVEL}) begin
         supply_level_select <= wb_dat_i[0];
      end
   end

   // power-on clear zeroes cause; read also clears
   always_ff @(posedge clk_sys) begin
      if (srst || por_reset) begin
         brownout_cause_flag <= CAUSE_RESET[CAUSE_BROWN];
         watchdog_cause_flag <= CAUSE_RESET[CAUSE_WDOG];
      end else begin
         if (brown_reset) begin
            brownout_cause_flag <= 1'b1;
         end else if (rd_cause) begin
            brownout_cause_flag <= 1'b0;
         end
         if (watchdog_reset) begin
            watchdog_cause_flag <= 1'b1;
         end else if (rd_cause) begin
            watchdog_cause_flag <= 1'b0;
         end
      end
   end

   // no stop gating, runs every clock
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         below_prev <= 1'b0;
         detector_interrupt <= 1'b0;
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         below_prev <= below_sel;
         detector_interrupt <= ~detect_action_select & (below_sel != below_prev);
         if (wr && wb_adr_i == ADR_MASK_FULL) begin
            irq_mask <= wb_dat_i[1:0];
         end
         // Set wins over write-one clear
         irq_stat[IRQ_FALL] <= (~detect_action_select & below_sel & ~below_prev)
            | (irq_stat[IRQ_FALL] & ~(wr && wb_adr_i == {2'b00, ADR_IRQ_STAT} && wb_dat_i[IRQ_FALL]));
         irq_stat[IRQ_RISE] <= (~detect_action_select & ~below_sel & below_prev)
            | (irq_stat[IRQ_RISE] & ~(wr && wb_adr_i == {2'b00, ADR_IRQ_STAT} && wb_dat_i[IRQ_RISE]));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq <= 1'b0;
         internal_reset <= 1'b1;
      end else begin
         irq <= |(irq_stat & irq_mask);
         internal_reset <= por_reset | brown_reset;
      end
   end

   // Single-wait-state slave; unmapped reads return zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         case (wb_adr_i)
            {2'b00, ADR_CTRL}: wb_dat_o <= {24'h0, detector_enable_bit, 4'h0, detect_source_select,
               detect_action_select, below_sel};
            {2'b00, ADR_LEVEL}: wb_dat_o <= {31'h0, supply_level_select};
            {2'b00, ADR_CAUSE}: wb_dat_o <= {27'h0, watchdog_cause_flag, 3'h0, brownout_cause_flag};
            {2'b00, ADR_IRQ_STAT}: wb_dat_o <= {30'h0, irq_stat};
            ADR_MASK_FULL: wb_dat_o <= {30'h0, irq_mask};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end
endmodule : pocbd_top

//--- sim/pocbd_analog.sv
`timescale 1ns/1ns
module pocbd_analog (
   input wire logic [12:0] supply_mv,
   input wire logic level_sel,
   output logic above_clear,
   output logic above_high,
   output logic supply_above
);
   assign supply_above = supply_mv >= (level_sel ? 13'h0FFA : 13'h1090);
   assign above_clear = supply_mv >= 13'h0636;
   assign above_high = supply_mv >= 13'h0A8C;
endmodule : pocbd_analog

//--- sim/pocbd_monitor.sv
`timescale 1ns/1ns
module pocbd_monitor (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic threshold_option_bit,
   input wire logic above_clear_async,
   input wire logic above_high_async,
   input wire logic [5:0] wb_adr_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic internal_reset,
   input wire logic detector_interrupt,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   property p_ack_next; req |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_unmapped; req && !wb_we_i && wb_adr_i == 6'h14 |=> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_srst; disable iff (1'b0) srst |=> internal_reset && !irq; endproperty
   a_srst: assert property (p_srst) else $error("reset outputs wrong");
   property p_clear_fall; $fell(above_clear_async) |-> ##[1:8] internal_reset; endproperty
   a_clear_fall: assert property (p_clear_fall) else $error("no reset on low supply");
   property p_low_release; !threshold_option_bit && $rose(above_clear_async) |-> ##[2:8] $fell(internal_reset); endproperty
   a_low_release: assert property (p_low_release) else $error("low option release missing");
   property p_dual_hold; threshold_option_bit && internal_reset && !above_high_async |=> internal_reset; endproperty
   a_dual_hold: assert property (p_dual_hold) else $error("dual option released early");
   property p_int_pulse; detector_interrupt |=> !detector_interrupt; endproperty
   a_int_pulse: assert property (p_int_pulse) else $error("interrupt not a pulse");
   c_brown: cover property ($rose(internal_reset));
   c_int: cover property (detector_interrupt);
   c_irq: cover property ($fell(irq));
endmodule : pocbd_monitor
bind pocbd_top pocbd_monitor u_monitor (.*);

//--- sim/pocbd_top_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %0t %0h %0h", $time, a, e); end end
module pocbd_top_tb;
   logic clk_sys = 1'b0, srst = 1'b1, threshold_option_bit = 1'b1, pin_above_async = 1'b1, watchdog_reset = 1'b0;
   logic above_clear_async, above_high_async, supply_above_async;
   logic [12:0] supply_mv = 13'h0;
   logic [5:0] wb_adr_i = 6'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, internal_reset, detector_interrupt, irq, supply_level_select;
   int error_cnt = 0, check_count = 0, cyc_cnt = 0, int_cnt = 0;
   // Short counts keep the run brief
   pocbd_top #(.FAST_RISE(20), .STAB_WAIT(10)) dut (.*);
   pocbd_analog model (.supply_mv(supply_mv), .level_sel(supply_level_select), .above_clear(above_clear_async),
      .above_high(above_high_async), .supply_above(supply_above_async));
   always #4 clk_sys = ~clk_sys;
   task automatic results();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         results();
      end
   end
   always @(posedge clk_sys) begin
      if (detector_interrupt === 1'b1) int_cnt++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      if (!w) `CHK(wb_dat_o[7:0], d)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask : acc
   initial begin
      tick(4);
      srst <= 1'b0;
      tick(3);
      supply_mv <= 13'h07D0;
      tick(3);
      supply_mv <= 13'h1388;
      tick(8);
      `CHK(internal_reset, 1'b1)
      tick(30);
      `CHK(internal_reset, 1'b0)
      acc(6'h08, 1'b0, 8'h00);
      acc(6'h00, 1'b0, 8'h00);
      acc(6'h14, 1'b0, 8'h00);
      acc(6'h00, 1'b1, 8'h86);
      tick(3);
      pin_above_async <= 1'b0;
      tick(10);
      `CHK(internal_reset, 1'b1)
      pin_above_async <= 1'b1;
      tick(10);
      `CHK(internal_reset, 1'b0)
      acc(6'h00, 1'b0, 8'h86);
      acc(6'h08, 1'b0, 8'h01);
      acc(6'h08, 1'b0, 8'h00);
      supply_mv <= 13'h1068;
      acc(6'h00, 1'b1, 8'h82);
      tick(10);
      `CHK(internal_reset, 1'b1)
      supply_mv <= 13'h1388;
      tick(10);
      acc(6'h00, 1'b1, 8'h00);
      acc(6'h04, 1'b1, 8'h01);
      `CHK(supply_level_select, 1'b1)
      supply_mv <= 13'h1068;
      pin_above_async <= 1'b0;
      acc(6'h00, 1'b1, 8'h82);
      tick(10);
      `CHK(internal_reset, 1'b0)
      acc(6'h10, 1'b1, 8'h03);
      acc(6'h00, 1'b1, 8'h04);
      tick(8);
      acc(6'h00, 1'b0, 8'h04);
      acc(6'h00, 1'b1, 8'h84);
      tick(8);
      acc(6'h00, 1'b0, 8'h85);
      `CHK(irq, 1'b1)
      pin_above_async <= 1'b1;
      tick(8);
      acc(6'h0C, 1'b0, 8'h03);
      `CHK(int_cnt, 2)
      acc(6'h10, 1'b1, 8'h00);
      tick(1);
      `CHK(irq, 1'b0)
      acc(6'h0C, 1'b1, 8'h03);
      acc(6'h10, 1'b1, 8'h03);
      tick(1);
      `CHK(irq, 1'b0)
      watchdog_reset <= 1'b1;
      tick(1);
      watchdog_reset <= 1'b0;
      tick(8);
      acc(6'h00, 1'b0, 8'h00);
      threshold_option_bit <= 1'b0;
      supply_mv <= 13'h03E8;
      tick(10);
      `CHK(internal_reset, 1'b1)
      supply_mv <= 13'h07D0;
      tick(10);
      `CHK(internal_reset, 1'b0)
      acc(6'h08, 1'b0, 8'h00);
      results();
   end
endmodule : pocbd_top_tb
